// >>> fce_pkg.sv
// Constants and types shared by the flash control and boot entry block.
// Assumes a 100 MHz system clock; one state equals one clock period.
package fce_pkg;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] FCE_OFS_MODE = 8'h00;
    localparam logic [7:0] FCE_OFS_STAT = 8'h04;
    localparam logic [7:0] FCE_OFS_EBS = 8'h08;
    localparam logic [7:0] FCE_OFS_GATE = 8'h0c;
    // ****************************************
    // Field positions and masks
    // ****************************************
    localparam int FCE_SWE_BIT = 6;
    localparam int FCE_ESU_BIT = 5;
    localparam int FCE_PSU_BIT = 4;
    localparam int FCE_E_BIT = 1;
    localparam int FCE_P_BIT = 0;
    localparam int FCE_ERR_BIT = 7;
    localparam int FCE_GATE_BIT = 7;
    localparam logic [7:0] FCE_MODE_MASK = 8'h7f;
    localparam logic [7:0] FCE_EBS_MASK = 8'h3f;
    localparam logic [7:0] FCE_REG_RST = 8'h00;
    // ****************************************
    // Erase blocks, index = select bit
    // ****************************************
    localparam logic [5:0][15:0] FCE_BLK_BASE = {16'h2000, 16'h1000, 16'h0c00,
                                                 16'h0800, 16'h0400, 16'h0000};
    localparam logic [15:0] FCE_BLK_4K = 16'h1000;
    localparam logic [15:0] FCE_BLK_1K = 16'h0400;
    // ****************************************
    // Boot loader
    // ****************************************
    localparam logic [15:0] FCE_RAM_LO = 16'hf980;
    localparam logic [15:0] FCE_RAM_HI = 16'hfeef;
    localparam logic [7:0] FCE_SYNC_BYTE = 8'h00;
    localparam logic [7:0] FCE_ACK_BYTE = 8'h55;
    localparam logic [7:0] FCE_OK_BYTE = 8'haa;
    localparam logic [7:0] FCE_FAIL_BYTE = 8'hff;
    localparam logic [15:0] FCE_LOW_BITS = 16'h0009;
    localparam int FCE_CLK_NS = 10;
    localparam int FCE_STATE_NS = 10;
    localparam int FCE_SETTLE_STATES = 100;
    localparam logic [15:0] FCE_SETTLE_CYC = 16'(FCE_SETTLE_STATES * FCE_STATE_NS / FCE_CLK_NS);
    typedef enum logic [3:0] {
        BT_IDLE, BT_SETTLE, BT_WAITLOW, BT_MEASURE, BT_SEND00, BT_WAIT55, BT_ERASE,
        BT_LENHI, BT_LENLO, BT_LOAD, BT_SENDAA, BT_DRAIN, BT_DONE, BT_FAIL
    } fce_boot_t;
endpackage

// >>> fce_uart_tx.sv
// Serial byte transmitter: 8 data bits, 1 stop bit, no parity, LSB first.
// Assumes bitTicks is stable while a byte is in flight.
module fce_uart_tx
    import fce_pkg::*;
#(
    parameter int TICK_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [TICK_W-1:0] bitTicks,
    input wire logic start,
    input wire logic [7:0] data,
    output logic busy,
    output logic txd
);
    logic [9:0] shift_q, shift_d;
    logic [3:0] bitCnt_q, bitCnt_d;
    logic [TICK_W-1:0] tmr_q, tmr_d;
    logic busy_q, busy_d;

    always_comb begin
        shift_d = shift_q;
        bitCnt_d = bitCnt_q;
        tmr_d = tmr_q;
        busy_d = busy_q;
        if (!busy_q && start) begin
            shift_d = {1'b1, data, 1'b0};
            bitCnt_d = 4'h0;
            tmr_d = bitTicks - 1'b1;
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (tmr_q == '0) begin
                tmr_d = bitTicks - 1'b1;
                shift_d = {1'b1, shift_q[9:1]};
                bitCnt_d = bitCnt_q + 4'h1;
                if (bitCnt_q == 4'h9) begin
                    busy_d = 1'b0;
                end
            end else begin
                tmr_d = tmr_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_q <= 10'h3ff;
            bitCnt_q <= 4'h0;
            tmr_q <= '0;
            busy_q <= 1'b0;
        end else begin
            shift_q <= shift_d;
            bitCnt_q <= bitCnt_d;
            tmr_q <= tmr_d;
            busy_q <= busy_d;
        end
    end

    assign busy = busy_q;
    assign txd = busy_q ? shift_q[0] : 1'b1;
endmodule

// >>> fce_flash_ctrl_boot.sv
// Flash control registers on APB and reset-time boot loader entry.
// Assumes APB master, flash array and RAM outside; pins synchronous to clk.
//
// Design decisions made here: the APB register port and the address map.
module fce_flash_ctrl_boot
    import fce_pkg::*;
#(
    parameter int TICK_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic testPin,
    input wire logic nmiPin,
    input wire logic bootSelPin,
    input wire logic flashOpError,
    input wire logic wdtOverflow,
    input wire logic rxd,
    output logic txd,
    output logic txdOe,
    output logic bootMode,
    output logic userMode,
    output logic rxEnable,
    output logic txEnable,
    output logic [TICK_W-1:0] baudDivisor,
    output logic eraseActive,
    output logic programActive,
    output logic [15:0] eraseBase,
    output logic [15:0] eraseSize,
    output logic eraseAllReq,
    input wire logic eraseAllDone,
    input wire logic eraseAllFail,
    output logic ramWrEn,
    output logic [15:0] ramAddr,
    output logic [7:0] ramData,
    output logic branchReq
);
    // ****************************************
    // Register file
    // ****************************************
    logic [7:0] mode_q, mode_d, ebs_q, ebs_d;
    logic gate_q, gate_d, err_q, err_d;
    logic [31:0] rdata_q, rdata_d;
    logic setup, wrAcc, hit, gatedHit;
    logic [7:0] wByte, ebsNew;

    assign setup = psel && !penable;
    assign wrAcc = psel && penable && pwrite;
    assign wByte = pwdata[7:0];
    assign hit = (paddr == FCE_OFS_MODE) || (paddr == FCE_OFS_STAT) ||
                 (paddr == FCE_OFS_EBS) || (paddr == FCE_OFS_GATE);
    assign gatedHit = hit && (paddr != FCE_OFS_GATE);

    always_comb begin
        mode_d = mode_q;
        ebs_d = ebs_q;
        gate_d = gate_q;
        rdata_d = rdata_q;
        ebsNew = wByte & FCE_EBS_MASK;
        err_d = err_q || flashOpError;
        if (wrAcc && paddr == FCE_OFS_GATE) begin
            gate_d = wByte[FCE_GATE_BIT];
        end
        // Status address never takes a write
        if (wrAcc && gate_q && paddr == FCE_OFS_MODE) begin
            if (mode_q[FCE_SWE_BIT]) begin
                mode_d = wByte & FCE_MODE_MASK;
            end else begin
                mode_d = FCE_REG_RST;
                mode_d[FCE_SWE_BIT] = wByte[FCE_SWE_BIT];
            end
        end
        if (wrAcc && gate_q && paddr == FCE_OFS_EBS && mode_q[FCE_SWE_BIT]) begin
            ebs_d = ($countones(ebsNew) > 1) ? FCE_REG_RST : ebsNew;
        end
        if (!mode_d[FCE_SWE_BIT]) begin
            ebs_d = FCE_REG_RST;
        end
        if (setup) begin
            rdata_d = '0;
            if (paddr == FCE_OFS_GATE) begin
                rdata_d[FCE_GATE_BIT] = gate_q;
            end else if (gatedHit && gate_q) begin
                case (paddr)
                    FCE_OFS_MODE: rdata_d[7:0] = mode_q;
                    FCE_OFS_STAT: rdata_d[FCE_ERR_BIT] = err_q;
                    default: rdata_d[7:0] = ebs_q;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= FCE_REG_RST;
            ebs_q <= FCE_REG_RST;
            gate_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            mode_q <= mode_d;
            ebs_q <= ebs_d;
            gate_q <= gate_d;
            err_q <= err_d;
            rdata_q <= rdata_d;
        end
    end

    // Zero wait states; read data is latched in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = rdata_q;

    // Error protection overrides erase and program, not the boot erase request
    assign eraseActive = !err_q && mode_q[FCE_SWE_BIT] && mode_q[FCE_ESU_BIT] && mode_q[FCE_E_BIT];
    assign programActive = !err_q && mode_q[FCE_SWE_BIT] && mode_q[FCE_PSU_BIT] && mode_q[FCE_P_BIT];

    // ****************************************
    // Erase block decode
    // ****************************************
    always_comb begin
        eraseBase = '0;
        eraseSize = '0;
        for (int i = 0; i < 6; i++) begin
            if (ebs_q[i]) begin
                eraseBase = FCE_BLK_BASE[i];
                eraseSize = (i > 3) ? FCE_BLK_4K : FCE_BLK_1K;
            end
        end
    end

    // ****************************************
    // Mode pin capture and boot sequencer
    // ****************************************
    fce_boot_t st_q, st_d;
    logic started_q, started_d, boot_q, boot_d, user_q, user_d;
    logic [15:0] cnt_q, cnt_d, len_q, len_d;
    logic [TICK_W-1:0] ticks_q, ticks_d;
    logic txStart, txBusy, txLine, rxOn, rxValid;
    logic [7:0] txData, rxByte;

    always_comb begin
        st_d = st_q;
        started_d = 1'b1;
        boot_d = boot_q;
        user_d = user_q;
        cnt_d = cnt_q;
        len_d = len_q;
        ticks_d = ticks_q;
        txStart = 1'b0;
        txData = FCE_SYNC_BYTE;
        eraseAllReq = 1'b0;
        ramWrEn = 1'b0;
        branchReq = 1'b0;
        // Pins are caught on the first edge after release; the reset
        // itself only clears state
        if (!started_q) begin
            user_d = !testPin && nmiPin;
            boot_d = !testPin && !nmiPin && bootSelPin;
        end
        case (st_q)
            BT_IDLE: begin
                cnt_d = '0;
                if (boot_q) begin
                    st_d = BT_SETTLE;
                end
            end
            BT_SETTLE: begin
                cnt_d = cnt_q + 16'h1;
                if (cnt_q == FCE_SETTLE_CYC - 16'h1) begin
                    st_d = BT_WAITLOW;
                end
            end
            BT_WAITLOW: begin
                cnt_d = 16'h1;
                if (!rxd) begin
                    st_d = BT_MEASURE;
                end
            end
            BT_MEASURE: begin
                cnt_d = cnt_q + 16'h1;
                if (rxd) begin
                    // Start bit plus eight zero data bits
                    ticks_d = TICK_W'(cnt_q / FCE_LOW_BITS);
                    st_d = BT_SEND00;
                end
            end
            BT_SEND00: begin
                txStart = 1'b1;
                st_d = BT_WAIT55;
            end
            BT_WAIT55: begin
                // Leftover sync bytes from the host are dropped here
                if (rxValid && rxByte == FCE_ACK_BYTE) begin
                    eraseAllReq = 1'b1;
                    st_d = BT_ERASE;
                end
            end
            BT_ERASE: begin
                if (eraseAllFail) begin
                    txStart = 1'b1;
                    txData = FCE_FAIL_BYTE;
                    st_d = BT_FAIL;
                end else if (eraseAllDone) begin
                    txStart = 1'b1;
                    txData = FCE_OK_BYTE;
                    st_d = BT_LENHI;
                end
            end
            BT_LENHI: begin
                txData = rxByte;
                if (rxValid) begin
                    txStart = 1'b1;
                    len_d = {rxByte, 8'h00};
                    st_d = BT_LENLO;
                end
            end
            BT_LENLO: begin
                txData = rxByte;
                cnt_d = '0;
                if (rxValid) begin
                    txStart = 1'b1;
                    len_d = {len_q[15:8], rxByte};
                    st_d = ({len_q[15:8], rxByte} == '0) ? BT_SENDAA : BT_LOAD;
                end
            end
            BT_LOAD: begin
                txData = rxByte;
                if (rxValid) begin
                    txStart = 1'b1;
                    ramWrEn = 1'b1;
                    cnt_d = cnt_q + 16'h1;
                    // The byte at the window's last address ends the load early
                    if (cnt_q + 16'h1 == len_q || FCE_RAM_LO + cnt_q == FCE_RAM_HI) begin
                        st_d = BT_SENDAA;
                    end
                end
            end
            BT_SENDAA: begin
                txData = FCE_OK_BYTE;
                if (!txBusy) begin
                    txStart = 1'b1;
                    st_d = BT_DRAIN;
                end
            end
            BT_DRAIN: begin
                if (!txBusy) begin
                    branchReq = 1'b1;
                    st_d = BT_DONE;
                end
            end
            BT_DONE, BT_FAIL: begin
                st_d = st_q;
            end
            default: begin
                st_d = BT_IDLE;
            end
        endcase
        if (wdtOverflow) begin
            boot_d = 1'b0;
            st_d = BT_IDLE;
            txStart = 1'b0;
            eraseAllReq = 1'b0;
            ramWrEn = 1'b0;
            branchReq = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= BT_IDLE;
            started_q <= 1'b0;
            boot_q <= 1'b0;
            user_q <= 1'b0;
            cnt_q <= '0;
            len_q <= '0;
            ticks_q <= TICK_W'(1);
        end else begin
            st_q <= st_d;
            started_q <= started_d;
            boot_q <= boot_d;
            user_q <= user_d;
            cnt_q <= cnt_d;
            len_q <= len_d;
            ticks_q <= ticks_d;
        end
    end

    assign ramAddr = FCE_RAM_LO + cnt_q;
    assign ramData = rxByte;
    assign bootMode = boot_q;
    assign userMode = user_q;
    // Divisor survives the branch for the downloaded program
    assign baudDivisor = ticks_q;
    assign rxOn = (st_q >= BT_WAIT55) && (st_q <= BT_LOAD);
    assign rxEnable = boot_q && rxOn;
    // Failure byte must still reach the pin before the halt
    assign txEnable = boot_q && (((st_q >= BT_SEND00) && (st_q <= BT_DRAIN)) || (st_q == BT_FAIL && txBusy));
    assign txd = txEnable ? txLine : 1'b1;
    assign txdOe = boot_q;

    // ****************************************
    // Serial receiver, 8N1, mid-bit sampling
    // ****************************************
    logic rxBusy_q, rxBusy_d, rxVal_q, rxVal_d;
    logic [3:0] rxIdx_q, rxIdx_d;
    logic [TICK_W-1:0] rxTmr_q, rxTmr_d;
    logic [7:0] rxSh_q, rxSh_d;

    always_comb begin
        rxBusy_d = rxBusy_q;
        rxIdx_d = rxIdx_q;
        rxTmr_d = rxTmr_q;
        rxSh_d = rxSh_q;
        rxVal_d = 1'b0;
        if (!rxOn) begin
            rxBusy_d = 1'b0;
        end else if (!rxBusy_q && !rxd) begin
            rxBusy_d = 1'b1;
            rxIdx_d = 4'h0;
            rxTmr_d = ticks_q >> 1;
        end else if (rxBusy_q && rxTmr_q != '0) begin
            rxTmr_d = rxTmr_q - 1'b1;
        end else if (rxBusy_q) begin
            rxTmr_d = ticks_q - 1'b1;
            rxIdx_d = rxIdx_q + 4'h1;
            if (rxIdx_q == 4'h0 && rxd) begin
                rxBusy_d = 1'b0;
            end else if (rxIdx_q == 4'h9) begin
                rxBusy_d = 1'b0;
                rxVal_d = rxd;
            end else if (rxIdx_q != 4'h0) begin
                rxSh_d = {rxd, rxSh_q[7:1]};
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxBusy_q <= 1'b0;
            rxVal_q <= 1'b0;
            rxIdx_q <= 4'h0;
            rxTmr_q <= '0;
            rxSh_q <= '0;
        end else begin
            rxBusy_q <= rxBusy_d;
            rxVal_q <= rxVal_d;
            rxIdx_q <= rxIdx_d;
            rxTmr_q <= rxTmr_d;
            rxSh_q <= rxSh_d;
        end
    end

    assign rxValid = rxVal_q;
    assign rxByte = rxSh_q;

    fce_uart_tx #(.TICK_W(TICK_W)) u_tx (
        .clk(clk),
        .rst(rst),
        .bitTicks(ticks_q),
        .start(txStart),
        .data(txData),
        .busy(txBusy),
        .txd(txLine)
    );

    // ****************************************
    // Checks
    // ****************************************
    a_err_sticky: assert property (@(posedge clk) disable iff (rst)
        flashOpError |=> err_q ##1 err_q) else $error("error flag lost");
    a_err_blocks: assert property (@(posedge clk) disable iff (rst)
        err_q |-> !eraseActive && !programActive) else $error("array op under error");
    a_ebs_swe: assert property (@(posedge clk) disable iff (rst)
        !mode_q[FCE_SWE_BIT] |-> ebs_q == '0) else $error("block select not zero");
    a_ebs_single: assert property (@(posedge clk) disable iff (rst)
        $countones(ebs_q) <= 1) else $error("several blocks selected");
    a_gate_read: assert property (@(posedge clk) disable iff (rst)
        setup && !gate_q && paddr != FCE_OFS_GATE |=> prdata == '0) else $error("gated read leaked");
    a_settle_time: assert property (@(posedge clk) disable iff (rst)
        $rose(st_q == BT_WAITLOW) |-> $past(cnt_q) == FCE_SETTLE_CYC - 16'h1) else $error("settle wrong");
    a_branch_quiet: assert property (@(posedge clk) disable iff (rst)
        branchReq |=> txd && !rxEnable && !txEnable && baudDivisor == $past(ticks_q))
        else $error("link not idle at branch");
    a_wdt_exit: assert property (@(posedge clk) disable iff (rst)
        wdtOverflow |=> !bootMode && st_q == BT_IDLE) else $error("boot survived watchdog");
    a_erase_cond: assert property (@(posedge clk) disable iff (rst)
        eraseActive |-> mode_q[FCE_SWE_BIT] && mode_q[FCE_ESU_BIT]) else $error("erase without setup");
endmodule

// >>> fce_host_model.sv
// Host end of the boot serial link: 8N1 bytes, LSB first.
// Assumes the bench calls its tasks just after a rising clock edge.
module fce_host_model #(
    parameter int BIT = 16
) (
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Byte tasks
    // ****************************************
    initial rxd = 1'h1; // Line high at reset release
    task automatic send(input logic [7:0] b);
        rxd <= 1'h0; // Start, 8 data, 1 stop, no parity
        repeat (BIT) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rxd <= b[i];
            repeat (BIT) @(posedge clk);
        end
        rxd <= 1'h1;
        repeat (BIT) @(posedge clk);
    endtask
    // Stop bit lands in r[8]; left 0 on a timeout so the caller sees it
    task automatic recv(output logic [8:0] r);
        int n;
        n = 0;
        r = 9'h0;
        while (txd !== 1'h0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (n < 4000) begin
            repeat (BIT / 2) @(posedge clk);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT) @(posedge clk);
                r[i] = txd;
            end
        end
    endtask
endmodule

// >>> flash_ctrl_boot_entry_tb.sv
// Bench for the flash control registers and the boot loader entry.
// Assumes the host model on the serial pins; APB is driven from here.
module flash_ctrl_boot_entry_tb import fce_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT = 16;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, testPin, nmiPin, bootSelPin, errv;
    logic flashOpError, wdtOverflow, rxd, txd, txdOe, bootMode, userMode, rxEnable, txEnable;
    logic eraseActive, programActive, eraseAllReq, eraseAllDone, eraseAllFail, ramWrEn, branchReq;
    logic [7:0] paddr, ramData, wrData;
    logic [31:0] pwdata, prdata, rdv;
    logic [15:0] baudDivisor, eraseBase, eraseSize, ramAddr, wrAddr;
    logic [8:0] rx;
    int nMismatch, samplesChecked, nWr, nReq, nBr;
    fce_flash_ctrl_boot i_fce_flash_ctrl_boot (
        .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .testPin, .nmiPin, .bootSelPin, .flashOpError, .wdtOverflow, .rxd, .txd, .txdOe,
        .bootMode, .userMode, .rxEnable, .txEnable, .baudDivisor, .eraseActive, .programActive,
        .eraseBase, .eraseSize, .eraseAllReq, .eraseAllDone, .eraseAllFail, .ramWrEn, .ramAddr,
        .ramData, .branchReq
    );
    fce_host_model #(.BIT(BIT)) i_fce_host_model (.clk, .txd, .rxd);
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (ramWrEn === 1'h1) begin
            nWr++;
            wrAddr = ramAddr;
            wrData = ramData;
        end
        if (eraseAllReq === 1'h1) nReq++;
        if (branchReq === 1'h1) nBr++;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            nMismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // A failed wait ends the run at once
    task automatic need(input int got, input string what);
        if (got == 0) begin
            chk(what, 32'h1, 32'h0);
            finish_test();
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        need(pready === 1'h1, "pready");
        rdv = prdata;
        errv = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        #1;
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk($sformatf("read %h", a), exp, rdv);
    endtask
    task automatic rst_seq(input logic t, input logic n, input logic b, input int cyc);
        testPin <= t; // Pins set long before release, then left alone
        nmiPin <= n;
        bootSelPin <= b;
        rst <= 1'h1;
        repeat (cyc) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        #1;
    endtask
    task automatic getb(input logic [7:0] exp);
        i_fce_host_model.recv(rx);
        need(rx[8] === 1'h1, "stop bit");
        chk("serial byte", exp, rx[7:0]);
    endtask
    // Device replies with the byte it was sent
    task automatic xfer(input logic [7:0] b);
        fork
            i_fce_host_model.send(b);
            getb(b);
        join
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        chk("user mode", 1'h1, userMode);
        chk("boot mode", 1'h0, bootMode);
        rdx(FCE_OFS_GATE, 32'h0);
        apb(1'h1, FCE_OFS_MODE, 32'h40);
        rdx(FCE_OFS_MODE, 32'h0);
        apb(1'h1, FCE_OFS_GATE, 32'hff);
        rdx(FCE_OFS_GATE, 32'h80);
        rdx(FCE_OFS_MODE, 32'h0);
        apb(1'h1, FCE_OFS_EBS, 32'h1);
        rdx(FCE_OFS_EBS, 32'h0);
        apb(1'h1, FCE_OFS_MODE, 32'hff);
        rdx(FCE_OFS_MODE, 32'h40);
        apb(1'h1, FCE_OFS_MODE, 32'h60);
        apb(1'h1, FCE_OFS_MODE, 32'h62);
        chk("erase active", 1'h1, eraseActive);
        apb(1'h1, FCE_OFS_MODE, 32'h40);
        apb(1'h1, FCE_OFS_MODE, 32'h42);
        chk("erase active", 1'h0, eraseActive);
        apb(1'h1, FCE_OFS_MODE, 32'h51);
        chk("program active", 1'h1, programActive);
        apb(1'h0, 8'h10, 32'h0);
        chk("slave error", 1'h1, errv);
        chk("unmapped read", 32'h0, rdv);
        $display("test regs done");
    endtask
    task automatic t_ebs();
        for (int i = 0; i < 6; i++) begin
            apb(1'h1, FCE_OFS_EBS, 32'h1 << i);
            rdx(FCE_OFS_EBS, 32'h1 << i);
            chk("erase base", i < 4 ? i * 32'h400 : (i - 3) * 32'h1000, eraseBase);
            chk("erase size", i < 4 ? 32'h400 : 32'h1000, eraseSize);
        end
        apb(1'h1, FCE_OFS_EBS, 32'h3);
        rdx(FCE_OFS_EBS, 32'h0);
        apb(1'h1, FCE_OFS_EBS, 32'h20);
        apb(1'h1, FCE_OFS_MODE, 32'h0);
        rdx(FCE_OFS_EBS, 32'h0);
        $display("test block select done");
    endtask
    task automatic t_err();
        @(posedge clk);
        flashOpError <= 1'h1;
        @(posedge clk);
        flashOpError <= 1'h0;
        rdx(FCE_OFS_STAT, 32'h80);
        apb(1'h1, FCE_OFS_STAT, 32'h0);
        rdx(FCE_OFS_STAT, 32'h80);
        apb(1'h1, FCE_OFS_MODE, 32'h60);
        apb(1'h1, FCE_OFS_MODE, 32'h62);
        chk("erase active", 1'h0, eraseActive);
        apb(1'h1, FCE_OFS_MODE, 32'h51);
        chk("program active", 1'h0, programActive);
        $display("test error flag done");
    endtask
    task automatic t_boot();
        rst_seq(1'h0, 1'h0, 1'h1, 25);
        chk("boot mode", 1'h1, bootMode);
        chk("tx drive", 1'h1, txdOe);
        repeat (120) @(posedge clk);
        xfer(8'h00);
        chk("divisor", BIT, baudDivisor);
        fork
            i_fce_host_model.send(8'h55);
            for (int k = 0; k < 4000 && nReq == 0; k++) @(posedge clk);
        join
        need(nReq, "erase request");
        fork
            begin
                eraseAllDone <= 1'h1;
                @(posedge clk);
                eraseAllDone <= 1'h0;
            end
            getb(8'haa);
        join
        xfer(8'h00);
        xfer(8'h01);
        xfer(8'h5a);
        chk("ram writes", 32'h1, nWr);
        chk("ram address", 16'hf980, wrAddr);
        chk("ram data", 8'h5a, wrData);
        getb(8'haa);
        for (int k = 0; k < 4000 && nBr == 0; k++) @(posedge clk);
        need(nBr, "branch");
        repeat (2) @(posedge clk);
        #1;
        chk("rx enable", 1'h0, rxEnable);
        chk("tx enable", 1'h0, txEnable);
        chk("tx level", 1'h1, txd);
        chk("divisor", BIT, baudDivisor);
        chk("tx drive", 1'h1, txdOe);
        $display("test boot done");
    endtask
    task automatic t_fail();
        rst_seq(1'h0, 1'h0, 1'h1, 25);
        repeat (120) @(posedge clk);
        xfer(8'h00);
        eraseAllFail <= 1'h1;
        fork
            i_fce_host_model.send(8'h55);
            getb(8'hff);
        join
        eraseAllFail <= 1'h0;
        repeat (16) @(posedge clk);
        #1;
        chk("tx enable", 1'h0, txEnable);
        chk("tx level", 1'h1, txd);
        chk("branch count", 32'h1, nBr);
        $display("test erase fail done");
    endtask
    task automatic t_wdt();
        rst_seq(1'h0, 1'h0, 1'h1, 25);
        @(posedge clk);
        wdtOverflow <= 1'h1;
        @(posedge clk);
        wdtOverflow <= 1'h0;
        @(posedge clk);
        #1;
        chk("boot mode", 1'h0, bootMode);
        $display("test watchdog done");
    endtask
    initial begin
        {psel, penable, pwrite, flashOpError, wdtOverflow, eraseAllDone, eraseAllFail} = 7'h0;
        {paddr, pwdata} = 40'h0;
        {clk, testPin, nmiPin, bootSelPin} = 4'h2;
        rst = 1'h1;
        {nMismatch, samplesChecked, nWr, nReq, nBr} = 160'h0;
        rst_seq(1'h0, 1'h1, 1'h0, 2);
        t_regs();
        t_ebs();
        t_err();
        t_boot();
        t_fail();
        t_wdt();
        finish_test();
    end
endmodule
